// [design/pucl_pkg.sv]
/*
 Package for the power-up configuration loader: command codes, fault bit
 positions, temperature limits, timing figures and shared types.
 Assumes a 40 MHz core clock and a die temperature given in whole degrees C.
*/
package pucl_pkg;

  localparam int NCH = 2;
  localparam int FLT_W = 9;
  localparam int TEMP_W = 10;

  // fault bit positions inside one channel's status word
  localparam int FLT_VOUT_UV = 0;
  localparam int FLT_VOUT_OV = 1;
  localparam int FLT_VIN_UV = 2;
  localparam int FLT_VIN_OV = 3;
  localparam int FLT_IIN_OC = 4;
  localparam int FLT_IOUT_OC = 5;
  localparam int FLT_OT_INT = 6;
  localparam int FLT_OT_EXT = 7;
  localparam int FLT_COMM_MEM_LOGIC = 8;

  // host command codes
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_NVM_STORE = 8'h15;
  localparam logic [7:0] CMD_VOUT = 8'h21;
  localparam logic [7:0] CMD_CH_MODE = 8'hD0;
  localparam logic [7:0] CMD_GLOBAL_CONFIG = 8'hD1;
  localparam logic [7:0] CMD_SD_MASK = 8'hD2;
  localparam logic [7:0] CMD_GPIO_MASK = 8'hD3;

  // field positions
  localparam int GCFG_IGNORE_RCFG_BIT = 6;
  localparam int MODE_RANGE_BIT = 0;
  localparam int MODE_CCM_BIT = 1;
  localparam int MODE_LATCH_BIT = 2;

  // reset values
  localparam logic [FLT_W-1:0] SD_MASK_RST = 9'h000;
  localparam logic [FLT_W-1:0] GPIO_MASK_RST = 9'h000;
  localparam logic [2:0] MODE_RST = 3'h2;

  // die temperature limits, degrees C
  localparam logic signed [TEMP_W-1:0] TEMP_NVM_OFF_C = 10'sh082;
  localparam logic signed [TEMP_W-1:0] TEMP_NVM_ON_C = 10'sh07D;
  localparam logic signed [TEMP_W-1:0] TEMP_OT_C = 10'sh0A0;
  localparam logic signed [TEMP_W-1:0] TEMP_OT_HYST_C = 10'sh00A;

  // reference scaling: 0.25 mV per code, output 5.5x or 2.75x reference
  localparam logic [4:0] VREF_MUL_R0 = 5'h08;
  localparam logic [4:0] VREF_MUL_R1 = 5'h10;
  localparam logic [20:0] VREF_DIV = 21'h00000B;
  localparam logic [11:0] VREF_MAX = 12'hFFF;

  // timing
  localparam int CLK_KHZ = 32'h0000_9C40;
  localparam int INIT_TIME_MS = 32'h0000_0078;
  localparam int RB_TIME_MS = 32'h0000_005A;
  localparam int RETRY_TIME_MS = 32'h0000_0001;
  localparam int INIT_CYC_DEF = INIT_TIME_MS * CLK_KHZ;
  localparam int RB_CYC_DEF = RB_TIME_MS * CLK_KHZ;
  localparam int RETRY_CYC_DEF = RETRY_TIME_MS * CLK_KHZ;

  typedef enum logic [3:0] {
    ST_WAIT_UVLO = 4'h1,
    ST_LOAD = 4'h2,
    ST_WAIT_VIN = 4'h4,
    ST_RUN = 4'h8
  } pucl_state_type;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] data;
  } pucl_cmd_type;

endpackage

// [design/pucl_gate.sv]
/*
 Per-channel top/bottom gate sequencer built around a set/reset latch.
 Assumes clk_set is a one-cycle pulse and the comparator inputs are already
 synchronised to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pucl_gate (
  input wire logic clk,         // core clock
  input wire logic rst_n,       // synchronous reset
  input wire logic ce,          // clock enable
  input wire logic enable,      // switching allowed
  input wire logic clk_set,     // channel clock, sets the latch
  input wire logic peak_trip,   // peak current comparator, resets latch
  input wire logic rev_current, // inductor reverse current seen
  input wire logic ccm,         // continuous conduction mode
  output logic tg_q,            // top gate drive
  output logic bg_q             // bottom gate drive
);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tg_q <= 1'b0;
      bg_q <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        tg_q <= 1'b0;
        bg_q <= 1'b0;
      end else if (tg_q && peak_trip) begin
        tg_q <= 1'b0;
        bg_q <= 1'b1;
      end else if (clk_set) begin
        tg_q <= 1'b1;
        bg_q <= 1'b0;
      end else if (bg_q && !ccm && rev_current) begin
        // discontinuous mode drops the bottom switch on reverse current
        bg_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [design/pucl_core.sv]
/*
 Power-up configuration loader and digital control of a two-channel
 step-down controller: init sequencing, config load, address forming,
 temperature guards, page select, fault handling and gate sequencing.
 Assumes host commands arrive on their own link clock, resistor decode and
 memory contents come from logic on CLK, analog levels arrive asynchronously.
*/
// Summary of operation
// - page command picks channel for later commands
// - two fault pins with own masks, alert
// - maskable shutdown, latched or automatic retry
// - per-channel status bits name each fault
// - 12-bit reference, 5.5x or 2.75x scaling
// - new setpoint accepted after init unless write protected, applied at once
// - setpoint from resistors, memory or bus
// - clock sets top gate, comparator resets
// - memory writes off above 130, on below 125
// - fault logging writes only log region
// - switching off above 160, 10 hysteresis
// - init starts after undervoltage lockout release
// - init holds pins low, fault pins Hi-Z
// - init loads resistors and memory into commands
// - no resistors or ignore bit: memory only
// - address low bits from pin unless open
// - sequencing waits for input-on comparator
// - init takes 120 ms, readback 90 more
// - write protect restricts configuration writes
// - enable pins released after init and input-on
`timescale 1ns/100ps
`default_nettype none
module pucl_core import pucl_pkg::*; #(
  parameter int INIT_CYC = INIT_CYC_DEF,
  parameter int RB_CYC = RB_CYC_DEF,
  parameter int RETRY_CYC = RETRY_CYC_DEF
) (
  input wire logic CLK,                          // core clock, 40 MHz
  input wire logic RESETN,                       // core reset, active low
  input wire logic CE,                           // core clock enable
  input wire logic LINK_CLK,                     // host link clock
  input wire logic LINK_RESETN,                  // link reset, active low
  input wire logic LINK_CMD_VALID,               // host command offered
  input wire pucl_cmd_type LINK_CMD,             // host command word
  output logic LINK_BUSY,                        // command refused now
  input wire logic UVLO_OK,                      // lockout released, async
  input wire logic INPUT_ON_THRESHOLD_OK,                    // input above turn-on, async
  input wire logic WP,                           // write protect, async
  input wire logic [NCH-1:0] CHANNEL_ENABLE_PIN_I, // enable pin level
  output logic [NCH-1:0] CHANNEL_ENABLE_PIN_O,   // enable pin pull level
  output logic [NCH-1:0] CHANNEL_ENABLE_PIN_OE,  // enable pin pulled low
  input wire logic ADDR_SELECT_PIN_OPEN,         // address pin left open
  input wire logic [3:0] ADDR_SELECT_PIN_LEVEL,  // decoded address pin
  input wire logic RCFG_PRESENT,                 // config resistors found
  input wire logic [NCH-1:0][15:0] RCFG_VOUT,    // resistor setpoint, mV
  input wire logic [NCH-1:0][15:0] NVM_VOUT,     // stored setpoint, mV
  input wire logic [6:0] NVM_ADDR,               // stored bus address
  input wire logic [7:0] NVM_GCFG,               // stored global config
  input wire logic signed [TEMP_W-1:0] DIE_TEMP, // die temperature, C
  input wire logic TEMP_VALID,                   // new temperature strobe
  input wire logic [NCH-1:0][FLT_W-1:0] FAULT_EVENT, // fault detections
  input wire logic [NCH-1:0] CH_CLK_SET,         // channel clock pulses
  input wire logic [NCH-1:0] PEAK_CMP,           // peak comparator, async
  input wire logic [NCH-1:0] REV_CURRENT,        // reverse current, async
  output logic [NCH-1:0] TOP_GATE_DRIVE,         // top switch drive
  output logic [NCH-1:0] BOTTOM_GATE_DRIVE,      // bottom switch drive
  output logic [NCH-1:0] FAULT_OUTPUT_PIN_O,     // fault pin pull level
  output logic [NCH-1:0] FAULT_OUTPUT_PIN_OE,    // fault pin pulled low
  output logic ALERT_O,                          // alert pull level
  output logic ALERT_OE,                         // alert pulled low
  output logic [6:0] BUS_ADDR,                   // formed bus address
  output logic CUR_PAGE,                         // selected channel
  output logic [NCH-1:0][11:0] VREF_CODE,        // reference codes
  output logic [NCH-1:0][FLT_W-1:0] FAULT_STATUS, // sticky fault status
  output logic NVM_STORE,                        // config store pulse
  output logic NVM_LOG_WRITE,                    // fault log write pulse
  output logic NVM_WR_INHIBIT,                   // memory writes blocked
  output logic OT_SHUTDOWN,                      // overtemperature off
  output logic INIT_DONE,                        // initialisation over
  output logic TON_START,                        // turn-on delay starts
  output logic READBACK_VALID                    // telemetry readback ok
);

  localparam int CW = $clog2(INIT_CYC + RB_CYC + 1);
  localparam int RW = $clog2(RETRY_CYC + 1);
  localparam int SW = 3 + 3 * NCH;

  // link domain
  pucl_cmd_type cmd_lq;
  logic req_lq, ack_s1_lq, ack_s2_lq, rdy_s1_lq, rdy_s2_lq, busy_lq;
  logic link_take;
  // core domain
  logic ack_q, req_s1_q, req_s2_q, req_s3_q, cmd_stb;
  logic [SW-1:0] pin_s1_q, pin_s2_q;
  logic uvlo_s, vin_s, wp_s;
  logic [NCH-1:0] en_s, peak_s, rev_s;
  pucl_state_type state_q;
  logic [CW-1:0] cnt_q;
  logic init_done_q, rb_q, ton_q, page_q, ot_q, inh_q, store_q, log_q;
  logic pull_q, alert_q;
  logic [6:0] addr_q;
  logic [7:0] gcfg_q;
  logic [NCH-1:0][15:0] vout_q;
  logic [NCH-1:0][2:0] mode_q;
  logic [NCH-1:0][FLT_W-1:0] st_q, sdm_q, gpm_q;
  logic [NCH-1:0][11:0] vref_q;
  logic [NCH-1:0] off_q, en_oe_q, fo_oe_q, trip, clr, en_fall;
  logic [NCH-1:0] en_d1_q, tg, bg;
  logic [NCH-1:0][RW-1:0] rty_q;
  logic cfg_ok, use_nvm;

  function automatic logic [11:0] vref_of(input logic [15:0] mv,
                                          input logic range);
    logic [20:0] prod;
    logic [20:0] quo;
    prod = 21'(mv) * 21'(range ? VREF_MUL_R1 : VREF_MUL_R0);
    quo = prod / VREF_DIV;
    vref_of = (quo > 21'(VREF_MAX)) ? VREF_MAX : quo[11:0];
  endfunction

  // link side: take one command, hold it until the core acknowledges
  assign link_take = LINK_CMD_VALID && !busy_lq;
  always_ff @(posedge LINK_CLK) begin
    if (!LINK_RESETN) begin
      req_lq <= 1'b0;
      cmd_lq <= '0;
      busy_lq <= 1'b1;
      {ack_s1_lq, ack_s2_lq, rdy_s1_lq, rdy_s2_lq} <= 4'h0;
    end else begin
      ack_s1_lq <= ack_q;
      ack_s2_lq <= ack_s1_lq;
      rdy_s1_lq <= init_done_q;
      rdy_s2_lq <= rdy_s1_lq;
      if (link_take) begin
        cmd_lq <= LINK_CMD;
        req_lq <= !req_lq;
      end
      busy_lq <= link_take || (req_lq != ack_s2_lq) || !rdy_s2_lq;
    end
  end
  assign LINK_BUSY = busy_lq;

  // core side of the toggle handshake; cmd_lq is stable while pending
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      {req_s1_q, req_s2_q, req_s3_q, ack_q} <= 4'h0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else if (CE) begin
      req_s1_q <= req_lq;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      ack_q <= req_s2_q;
      pin_s1_q <= {UVLO_OK, INPUT_ON_THRESHOLD_OK, WP, CHANNEL_ENABLE_PIN_I, PEAK_CMP,
                   REV_CURRENT};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign cmd_stb = req_s2_q != req_s3_q;
  assign {uvlo_s, vin_s, wp_s, en_s, peak_s, rev_s} = pin_s2_q;
  // write protect leaves only page select and fault clearing open
  assign cfg_ok = init_done_q && !wp_s;
  assign use_nvm = !RCFG_PRESENT || gcfg_q[GCFG_IGNORE_RCFG_BIT];

  // power-up sequence
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_q <= ST_WAIT_UVLO;
      cnt_q <= '0;
      init_done_q <= 1'b0;
      ton_q <= 1'b0;
      rb_q <= 1'b0;
    end else if (CE) begin
      ton_q <= 1'b0;
      case (state_q)
        ST_WAIT_UVLO: begin
          cnt_q <= '0;
          if (uvlo_s) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CW'(INIT_CYC - 1)) begin
            state_q <= ST_WAIT_VIN;
            init_done_q <= 1'b1;
            ton_q <= 1'b1;
          end
        end
        ST_WAIT_VIN: begin
          if (vin_s) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_WAIT_UVLO;
        end
      endcase
      if (init_done_q && !rb_q) begin
        cnt_q <= cnt_q + 1'b1;
        rb_q <= cnt_q == CW'(INIT_CYC + RB_CYC - 1);
      end
    end
  end

  // configuration: global config read before init, setpoint and address loaded at end of init, host writes afterwards
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      page_q <= 1'b0;
      gcfg_q <= 8'h00;
      addr_q <= 7'h00;
      vout_q <= '0;
      mode_q <= {NCH{MODE_RST}};
      sdm_q <= {NCH{SD_MASK_RST}};
      gpm_q <= {NCH{GPIO_MASK_RST}};
    end else if (CE) begin
      if (state_q == ST_WAIT_UVLO) begin
        gcfg_q <= NVM_GCFG;
      end
      if (state_q == ST_LOAD && cnt_q == CW'(INIT_CYC - 1)) begin
        for (int c = 0; c < NCH; c++) begin
          vout_q[c] <= use_nvm ? NVM_VOUT[c] : RCFG_VOUT[c];
        end
        addr_q <= ADDR_SELECT_PIN_OPEN ? NVM_ADDR
                  : {NVM_ADDR[6:4], ADDR_SELECT_PIN_LEVEL};
      end
      if (cmd_stb && init_done_q) begin
        if (cmd_lq.code == CMD_PAGE
            && cmd_lq.data[15:1] == 15'h0000) begin
          page_q <= cmd_lq.data[0];
        end
        if (cfg_ok) begin
          case (cmd_lq.code)
            CMD_VOUT: vout_q[page_q] <= cmd_lq.data;
            CMD_CH_MODE: mode_q[page_q] <= cmd_lq.data[2:0];
            CMD_SD_MASK: sdm_q[page_q] <= cmd_lq.data[FLT_W-1:0];
            CMD_GPIO_MASK: gpm_q[page_q] <= cmd_lq.data[FLT_W-1:0];
            CMD_GLOBAL_CONFIG: gcfg_q <= cmd_lq.data[7:0];
            default: gcfg_q <= gcfg_q;
          endcase
        end
      end
    end
  end

  // temperature guards, refreshed on every conversion
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ot_q <= 1'b0;
      inh_q <= 1'b0;
    end else if (CE && TEMP_VALID) begin
      if (DIE_TEMP > TEMP_NVM_OFF_C) begin
        inh_q <= 1'b1;
      end else if (DIE_TEMP < TEMP_NVM_ON_C) begin
        inh_q <= 1'b0;
      end
      if (DIE_TEMP > TEMP_OT_C) begin
        ot_q <= 1'b1;
      end else if (DIE_TEMP <= TEMP_OT_C - TEMP_OT_HYST_C) begin
        ot_q <= 1'b0;
      end
    end
  end

  // memory write strobes; log writes use their own strobe and region
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      store_q <= 1'b0;
      log_q <= 1'b0;
    end else if (CE) begin
      store_q <= cmd_stb && cfg_ok && cmd_lq.code == CMD_NVM_STORE && !inh_q;
      log_q <= |(trip & ~off_q) && !inh_q;
    end
  end

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      assign trip[c] = |(FAULT_EVENT[c] & ~sdm_q[c]);
      assign clr[c] = cmd_stb && init_done_q && page_q == 1'(c)
                      && cmd_lq.code == CMD_CLEAR_FAULTS;
      assign en_fall[c] = en_d1_q[c] && !en_s[c];

      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          st_q[c] <= '0;
          off_q[c] <= 1'b0;
          rty_q[c] <= '0;
          en_d1_q[c] <= 1'b0;
          vref_q[c] <= 12'h000;
          en_oe_q[c] <= 1'b1;
          fo_oe_q[c] <= 1'b0;
        end else if (CE) begin
          en_d1_q[c] <= en_s[c];
          // a new fault in the clearing cycle stays recorded
          st_q[c] <= (st_q[c] & ~{FLT_W{clr[c]}}) | FAULT_EVENT[c];
          if (trip[c]) begin
            off_q[c] <= 1'b1;
            rty_q[c] <= RW'(RETRY_CYC - 1);
          end else if (off_q[c] && mode_q[c][MODE_LATCH_BIT]) begin
            off_q[c] <= !(clr[c] || en_fall[c]);
          end else if (off_q[c]) begin
            rty_q[c] <= rty_q[c] - 1'b1;
            off_q[c] <= rty_q[c] != '0;
          end
          vref_q[c] <= vref_of(vout_q[c], mode_q[c][MODE_RANGE_BIT]);
          en_oe_q[c] <= state_q != ST_RUN;
          fo_oe_q[c] <= init_done_q && |(st_q[c] & ~gpm_q[c]);
        end
      end

      pucl_gate u_gate (
        .clk(CLK),
        .rst_n(RESETN),
        .ce(CE),
        .enable(state_q == ST_RUN && en_s[c] && !off_q[c] && !ot_q),
        .clk_set(CH_CLK_SET[c]),
        .peak_trip(peak_s[c]),
        .rev_current(rev_s[c]),
        .ccm(mode_q[c][MODE_CCM_BIT]),
        .tg_q(tg[c]),
        .bg_q(bg[c])
      );
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pull_q <= 1'b0;
      alert_q <= 1'b0;
    end else if (CE) begin
      pull_q <= 1'b0;
      alert_q <= init_done_q && |st_q;
    end
  end

  assign TOP_GATE_DRIVE = tg;
  assign BOTTOM_GATE_DRIVE = bg;
  assign CHANNEL_ENABLE_PIN_O = {NCH{pull_q}};
  assign CHANNEL_ENABLE_PIN_OE = en_oe_q;
  assign FAULT_OUTPUT_PIN_O = {NCH{pull_q}};
  assign FAULT_OUTPUT_PIN_OE = fo_oe_q;
  assign ALERT_O = pull_q;
  assign ALERT_OE = alert_q;
  assign BUS_ADDR = addr_q;
  assign CUR_PAGE = page_q;
  assign VREF_CODE = vref_q;
  assign FAULT_STATUS = st_q;
  assign NVM_STORE = store_q;
  assign NVM_LOG_WRITE = log_q;
  assign NVM_WR_INHIBIT = inh_q;
  assign OT_SHUTDOWN = ot_q;
  assign INIT_DONE = init_done_q;
  assign TON_START = ton_q;
  assign READBACK_VALID = rb_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_load_end;
    state_q == ST_LOAD && CE && cnt_q == CW'(INIT_CYC - 1);
  endsequence
  sequence s_vout_wr;
    cmd_stb && CE && cfg_ok && cmd_lq.code == CMD_VOUT;
  endsequence

  a_page_select: assert property (cmd_stb && CE && init_done_q
    && cmd_lq.code == CMD_PAGE && cmd_lq.data[15:1] == 15'h0000
    |=> CUR_PAGE == $past(cmd_lq.data[0]))
    else $error("page not taken");
  a_init_pins_held: assert property (state_q == ST_LOAD && CE
    |=> FAULT_OUTPUT_PIN_OE == '0 && CHANNEL_ENABLE_PIN_OE == '1
        && TOP_GATE_DRIVE == '0 && BOTTOM_GATE_DRIVE == '0)
    else $error("pins not held during init");
  a_ton_start_pulse: assert property (s_load_end
    |=> TON_START && INIT_DONE && state_q == ST_WAIT_VIN)
    else $error("init end not signalled");
  a_load_hold: assert property (state_q == ST_LOAD
    && cnt_q != CW'(INIT_CYC - 1) |=> state_q == ST_LOAD)
    else $error("init left early");
  a_vin_wait: assert property (state_q == ST_WAIT_VIN && !vin_s
    |=> state_q == ST_WAIT_VIN ##1 CHANNEL_ENABLE_PIN_OE == '1 || !CE)
    else $error("sequencing before input on");
  a_nvm_inhibit_set: assert property (CE && TEMP_VALID
    && DIE_TEMP > TEMP_NVM_OFF_C |=> NVM_WR_INHIBIT ##1 !NVM_STORE)
    else $error("memory write not inhibited");
  a_nvm_inhibit_hold: assert property (NVM_WR_INHIBIT
    && !(CE && TEMP_VALID && DIE_TEMP < TEMP_NVM_ON_C) |=> NVM_WR_INHIBIT)
    else $error("inhibit released too soon");
  a_ot_gates_off: assert property (ot_q && CE
    |=> TOP_GATE_DRIVE == '0 && BOTTOM_GATE_DRIVE == '0)
    else $error("switching during overtemperature");
  a_vout_apply: assert property (s_vout_wr
    |=> vout_q[page_q] == $past(cmd_lq.data))
    else $error("setpoint not applied");
  a_early_cmd_ignored: assert property (state_q == ST_WAIT_UVLO
    && CE |=> $stable(page_q) && $stable(sdm_q))
    else $error("command taken before init");
  a_latch_holds: assert property (off_q[0] && mode_q[0][MODE_LATCH_BIT]
    && !clr[0] && !en_fall[0] |=> off_q[0])
    else $error("latched fault released");

endmodule
`default_nettype wire

// [verif/pucl_host.sv]
/*
 Host model for the command link: offers one command word at a time.
 Assumes the block answers only with a registered busy flag on link_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pucl_host import pucl_pkg::*; (
  input wire logic link_clk, // link clock
  input wire logic busy,     // command refused now
  output logic valid,        // command offered
  output pucl_cmd_type cmd   // command word
);
  initial begin
    valid = 1'b0;
    cmd = '0;
  end
  task automatic wait_free();
    int n;
    n = 0;
    // busy sampled mid-cycle, it only changes on rising edges
    do begin
      @(negedge link_clk);
      n++;
    end while (busy !== 1'b0 && n < 300);
  endtask
  task automatic send(input logic [7:0] code, input logic [15:0] data);
    wait_free();
    @(posedge link_clk);
    valid <= 1'b1;
    cmd <= '{code: code, data: data};
    @(posedge link_clk);
    valid <= 1'b0;
    // released word shows the inverse, never the last value
    cmd <= ~{code, data};
    wait_free();
  endtask
endmodule
`default_nettype wire

// [verif/pucl_core_tb.sv]
/*
 Self-checking bench for pucl_core with shortened init and retry counts.
 Assumes pucl_host drives the link and all other inputs come from here.
*/
`timescale 1ns/100ps
`default_nettype none
module pucl_core_tb import pucl_pkg::*;;
  localparam int IC = 20;
  localparam int RC = 10;
  logic clk = 0, lclk = 0, rstn = 0, uvlo = 0, vin = 0, tv = 0, wp = 0;
  logic ce = 1'b1;
  logic [1:0] en_i = 2'b00, cset = 2'b00, peak = 2'b00, rev = 2'b00;
  logic [7:0] gcfg = 8'h40;
  logic [1:0][15:0] nvm_v = {16'h0898, 16'h044C}, rc_v = {2{16'h0CE4}};
  logic signed [9:0] temp = 10'sh019;
  logic [1:0][8:0] fev = '0;
  wire logic busy, alert_oe, nvm_lw, inh, ot, idone, ton, rbv, page, valid;
  wire logic nvm_st;
  wire logic [4:0] pull;
  wire logic [1:0] en_oe, tg, bg, fp_oe;
  wire logic [6:0] addr;
  wire logic [1:0][11:0] vref;
  wire logic [1:0][8:0] fst;
  wire pucl_cmd_type cmd;
  int err_count = 0, total_checks = 0;
  int stores = 0;
  always #12.5 clk = ~clk;
  always #32 lclk = ~lclk;
  pucl_host host (.link_clk(lclk), .busy(busy), .valid(valid), .cmd(cmd));
  pucl_core #(.INIT_CYC(IC), .RB_CYC(RC), .RETRY_CYC(8)) uut (
    .CLK(clk), .RESETN(rstn), .CE(ce), .LINK_CLK(lclk),
    .LINK_RESETN(rstn), .LINK_CMD_VALID(valid), .LINK_CMD(cmd),
    .LINK_BUSY(busy), .UVLO_OK(uvlo), .INPUT_ON_THRESHOLD_OK(vin), .WP(wp),
    .CHANNEL_ENABLE_PIN_I(en_i), .CHANNEL_ENABLE_PIN_O(pull[1:0]),
    .CHANNEL_ENABLE_PIN_OE(en_oe), .ADDR_SELECT_PIN_OPEN(1'b0),
    .ADDR_SELECT_PIN_LEVEL(4'h3), .RCFG_PRESENT(1'b1), .RCFG_VOUT(rc_v),
    .NVM_VOUT(nvm_v), .NVM_ADDR(7'h5A), .NVM_GCFG(gcfg), .DIE_TEMP(temp),
    .TEMP_VALID(tv), .FAULT_EVENT(fev), .CH_CLK_SET(cset), .PEAK_CMP(peak),
    .REV_CURRENT(rev), .TOP_GATE_DRIVE(tg), .BOTTOM_GATE_DRIVE(bg),
    .FAULT_OUTPUT_PIN_O(pull[3:2]), .FAULT_OUTPUT_PIN_OE(fp_oe),
    .ALERT_O(pull[4]), .ALERT_OE(alert_oe), .BUS_ADDR(addr),
    .CUR_PAGE(page), .VREF_CODE(vref), .FAULT_STATUS(fst),
    .NVM_STORE(nvm_st), .NVM_LOG_WRITE(nvm_lw),
    .NVM_WR_INHIBIT(inh), .OT_SHUTDOWN(ot), .INIT_DONE(idone),
    .TON_START(ton), .READBACK_VALID(rbv));
  // one-cycle store pulse, counted mid-cycle where it is settled
  always @(negedge clk) if (nvm_st === 1'b1) stores++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_init();
    int n;
    #1;
    chk({en_oe, tg, bg, fp_oe, busy, pull}, 14'h3020);
    @(posedge clk) uvlo <= 1'b1;
    for (n = 0; n < 60 && idone !== 1'b1; n++) begin
      cyc(1);
      if (n == IC / 2) chk({busy, idone}, 2'b10);
    end
    chk(n >= IC && n <= IC + 4, 1'b1);
    chk(ton, 1'b1);
    chk(addr, 7'h53);
    // reference code follows the loaded setpoint one cycle later
    cyc(1);
    chk({vref[1], vref[0]}, 24'h640320);
    chk(en_oe, 2'b11);
    for (n = 0; n < 40 && rbv !== 1'b1; n++) cyc(1);
    chk(n >= RC - 1 && n <= RC + 2, 1'b1);
    @(posedge clk) vin <= 1'b1;
    en_i <= 2'b11;
    cyc(4);
    chk(en_oe, 2'b00);
  endtask
  task automatic pulse_set();
    @(posedge clk) cset <= 2'b01;
    @(posedge clk) cset <= 2'b00;
    #1;
  endtask
  task automatic t_gate();
    // a frozen core must ignore the set pulse
    @(posedge clk) ce <= 1'b0;
    pulse_set();
    cyc(2);
    chk({tg[0], bg[0]}, 2'b00);
    @(posedge clk) ce <= 1'b1;
    pulse_set();
    chk({tg[0], bg[0]}, 2'b10);
    // continuous mode keeps bottom on despite reverse current
    @(posedge clk) peak <= 2'b01;
    rev <= 2'b01;
    cyc(5);
    chk({tg[0], bg[0]}, 2'b01);
    @(posedge clk) peak <= 2'b00;
    rev <= 2'b00;
  endtask
  task automatic t_cmd();
    host.send(CMD_PAGE, 16'h0001);
    chk(page, 1'b1);
    host.send(CMD_VOUT, 16'h0226);
    chk({vref[1], vref[0]}, 24'h190320);
    host.send(CMD_CH_MODE, 16'h0001);
    cyc(2);
    chk(vref[1], 12'h320);
    host.send(CMD_PAGE, 16'h0002);
    chk(page, 1'b1);
    @(posedge clk) wp <= 1'b1;
    host.send(CMD_VOUT, 16'h044C);
    chk(vref[1], 12'h320);
    host.send(CMD_PAGE, 16'h0000);
    chk(page, 1'b0);
    @(posedge clk) wp <= 1'b0;
  endtask
  task automatic set_temp(input logic signed [9:0] t, input logic [1:0] e);
    @(posedge clk) temp <= t;
    tv <= 1'b1;
    @(posedge clk) tv <= 1'b0;
    cyc(2);
    chk({inh, ot}, e);
  endtask
  task automatic t_fault();
    int seen;
    seen = 0;
    pulse_set();
    chk(tg[0], 1'b1);
    @(posedge clk) fev[0][FLT_VOUT_OV] <= 1'b1;
    @(posedge clk) fev[0][FLT_VOUT_OV] <= 1'b0;
    // the log pulse stands in the cycle right after the event edge
    #1;
    repeat (4) begin
      if (nvm_lw === 1'b1) seen++;
      cyc(1);
    end
    chk(seen, 1);
    chk(fst[0], 9'h002);
    chk({fp_oe, alert_oe, tg[0]}, 4'b0110);
    host.send(CMD_GPIO_MASK, 16'h0002);
    cyc(3);
    chk({fp_oe[0], alert_oe}, 2'b01);
    pulse_set();
    chk(tg[0], 1'b1);
    host.send(CMD_CH_MODE, 16'h0006);
    @(posedge clk) fev[0][FLT_IOUT_OC] <= 1'b1;
    @(posedge clk) fev[0][FLT_IOUT_OC] <= 1'b0;
    cyc(12);
    pulse_set();
    chk({tg[0], fp_oe[0], fst[0]}, 11'h222);
    host.send(CMD_CLEAR_FAULTS, 16'h0000);
    cyc(3);
    chk({fst[0], alert_oe}, 10'h000);
    pulse_set();
    chk(tg[0], 1'b1);
  endtask
  task automatic t_reinit();
    @(posedge clk) rstn <= 1'b0;
    gcfg <= 8'h00;
    cyc(6);
    chk({idone, en_oe, tg}, 5'h0C);
    @(posedge clk) rstn <= 1'b1;
    cyc(IC + 5);
    chk({idone, vref[1], vref[0]}, 25'h1960960);
  endtask
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_init();
    t_gate();
    t_cmd();
    set_temp(10'sh083, 2'b10);
    host.send(CMD_NVM_STORE, 16'h0000);
    cyc(2);
    chk(stores, 0);
    set_temp(10'sh07D, 2'b10);
    set_temp(10'sh07C, 2'b00);
    set_temp(10'sh0A1, 2'b11);
    set_temp(10'sh097, 2'b11);
    set_temp(10'sh096, 2'b10);
    set_temp(10'sh028, 2'b00);
    host.send(CMD_NVM_STORE, 16'h0000);
    cyc(2);
    chk(stores, 1);
    t_fault();
    t_reinit();
    test_done();
  end
endmodule
`default_nettype wire
